// ===== verilog/fbr_pkg.sv
// Shared constants for the fieldbus reset and frequency setup block.
package fbr_pkg;

	////////////////////////////////////////////////////////////////////////
	// Register byte offsets on the APB bus.
	localparam logic [7:0] FBR_OFF_CONFIG = 8'h00;
	localparam logic [7:0] FBR_OFF_LINK = 8'h04;
	localparam logic [7:0] FBR_OFF_STATUS = 8'h08;
	localparam logic [7:0] FBR_OFF_CMD = 8'h0C;
	localparam logic [7:0] FBR_OFF_SETPOINT = 8'h10;
	localparam logic [7:0] FBR_OFF_INSTR = 8'h14;
	localparam logic [7:0] FBR_OFF_FREQ = 8'h18;
	localparam logic [7:0] FBR_OFF_MODE = 8'h1C;

	////////////////////////////////////////////////////////////////////////
	// Field positions.
	localparam int FBR_CFG_SCOPE_BIT = 0;
	localparam int FBR_CFG_SIGN_BIT = 1;
	localparam int FBR_CFG_START_LSB = 4;
	localparam int FBR_CFG_EXT_LSB = 8;
	localparam int FBR_CFG_RES_LSB = 16;
	localparam int FBR_LINK_STN_LSB = 0;
	localparam int FBR_LINK_BAUD_LSB = 8;
	localparam int FBR_CMD_ERR_RST_BIT = 0;
	localparam int FBR_CMD_VOL_BIT = 1;
	localparam int FBR_CMD_NV_BIT = 2;
	localparam int FBR_CMD_DRV_RST_BIT = 3;
	localparam int FBR_CMD_FWD_BIT = 4;
	localparam int FBR_CMD_REV_BIT = 5;
	localparam int FBR_INSTR_DATA_LSB = 16;

	////////////////////////////////////////////////////////////////////////
	// Setting ranges, reset values and codes.
	localparam logic [6:0] FBR_STN_MIN = 7'h01;
	localparam logic [6:0] FBR_STN_MAX = 7'h40;
	localparam logic [6:0] FBR_STN_RESET = 7'h01;
	localparam logic [2:0] FBR_BAUD_MAX = 3'h4;
	localparam logic [2:0] FBR_BAUD_RESET = 3'h0;
	localparam logic [15:0] FBR_UNSIGNED_MAX = 16'hE678;
	localparam logic [7:0] FBR_FREQ_WRITE_VOLATILE_CODE = 8'hED;
	localparam logic [7:0] FBR_FREQ_WRITE_NONVOLATILE_CODE = 8'hEE;
	localparam logic [7:0] FBR_WRITE_MODE_ERROR_CODE = 8'h01;
	localparam logic [7:0] FBR_NO_ERROR_CODE = 8'h00;
	localparam logic [7:0] FBR_RES_FINE_A = 8'h01;
	localparam logic [7:0] FBR_RES_FINE_B = 8'h0B;

	////////////////////////////////////////////////////////////////////////
	// Timing.
	localparam int FBR_CLK_HZ = 125_000_000;
	localparam int FBR_LOCK_TIME_MS = 1000;
	localparam int FBR_LOCK_CYCLES = FBR_LOCK_TIME_MS * (FBR_CLK_HZ / 1000);
	localparam int FBR_BLINK_TIME_MS = 250;
	localparam int FBR_BLINK_CYCLES = FBR_BLINK_TIME_MS * (FBR_CLK_HZ / 1000);

	////////////////////////////////////////////////////////////////////////
	// Operation modes and reset sequencer states.
	typedef enum logic [1:0] {
		FBR_MODE_EXT = 2'b00,
		FBR_MODE_NET = 2'b01,
		FBR_MODE_PANEL = 2'b10
	} fbr_mode_t;

	typedef enum logic [1:0] {
		FBR_SEQ_IDLE = 2'b00,
		FBR_SEQ_PULSE = 2'b01,
		FBR_SEQ_LOCK = 2'b10
	} fbr_seq_t;

endpackage

// ===== verilog/fbr_setpoint.sv
// Decoder of the frequency setpoint word as unsigned or two's complement.
`timescale 1ns/1ps
module fbr_setpoint import fbr_pkg::*; (
	// Setpoint word and sign setting.
	input wire logic [15:0] word,
	input wire logic signed_mode,
	// Decoded magnitude in 0.01 Hz, sign and range check.
	output logic [15:0] mag,
	output logic neg,
	output logic in_range
);

	// Negative signed words are negated to a magnitude; unsigned words above 590.00 Hz are flagged out of range.
	always_comb begin
		if (signed_mode) begin
			neg = word[15];
			mag = word[15] ? 16'(~word + 16'h0001) : word;
			in_range = 1'b1;
		end else begin
			neg = 1'b0;
			mag = word;
			in_range = (word <= FBR_UNSIGNED_MAX);
		end
	end

endmodule

// ===== verilog/fbr_blink.sv
// Flasher for the link-error indicator, paced by an enable divider.
`timescale 1ns/1ps
module fbr_blink import fbr_pkg::*; #(
	parameter int unsigned HALF_CYCLES = FBR_BLINK_CYCLES
) (
	// Clock and reset.
	input wire logic core_clk,
	input wire logic sys_rst,
	// Flash request and indicator.
	input wire logic active,
	output logic led
);

	localparam int CW = $clog2(HALF_CYCLES + 1);

	logic [CW-1:0] cnt_q;
	logic tick;
	logic led_q;

	assign tick = (cnt_q == CW'(HALF_CYCLES - 1));
	assign led = led_q;

	// Divider making one enable pulse per half period while flashing.
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			cnt_q <= '0;
		end else if (!active || tick) begin
			cnt_q <= '0;
		end else begin
			cnt_q <= cnt_q + CW'(1);
		end
	end

	// Indicator toggles on each enable and goes dark when no flash is wanted.
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			led_q <= 1'b0;
		end else if (!active) begin
			led_q <= 1'b0;
		end else if (tick) begin
			led_q <= ~led_q;
		end
	end

endmodule

// ===== verilog/fbr_top.sv
// Reset acceptance, link settings and frequency setpoint handling of a fieldbus drive option.
//
// Overview of operation
// - Reset-scope 0 accepts network error reset in every operation mode.
// - Reset-scope 1 accepts network error reset only in network mode.
// - Error reset acts only while a protective trip is active.
// - Any network reset is rejected while a communication line error is present.
// - Reset in network mode returns to external mode when startup setting is zero.
// - Link stays up during reset; control commands ignored about 1 s afterwards.
// - Station number accepted within 1 to 64, default 1.
// - Baud codes 0 to 4 mean 156k, 625k, 2.5M, 5M, 10M; default 0.
// - Changed station or baud flashes indicator; applied at power-on or hard clear.
// - Sign setting 0 reads unsigned 0 to 59000, setting 1 two's complement.
// - Signed negative setpoint swaps commanded direction; positive keeps it.
// - Signed mode refuses nonvolatile setpoint write with write-mode error code.
// - Signed mode with both write bits executes only the volatile write.
// - Power-on or reset sets sign positive and frequency 0 Hz.
// - Frequency-write instruction codes leave the stored sign unchanged.
// - Resolution setting 1 or 11 selects 0.1 r/min speed steps.
//
// Added by the designer: the register addresses and the APB register port.
`timescale 1ns/1ps
module fbr_top import fbr_pkg::*; #(
	parameter int unsigned LOCK_CYCLES = FBR_LOCK_CYCLES,
	parameter int unsigned BLINK_CYCLES = FBR_BLINK_CYCLES
) (
	// Clock and reset.
	input wire logic core_clk,
	input wire logic sys_rst,
	// APB slave.
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Drive core status.
	input wire logic trip_active,
	input wire logic line_error,
	input wire logic hard_clear_terminal,
	// Drive core commands and state.
	output logic [1:0] op_mode,
	output logic error_reset_pulse,
	output logic drive_reset_pulse,
	output logic nvm_write_pulse,
	output logic run_fwd,
	output logic run_rev,
	output logic [15:0] freq_mag,
	output logic freq_neg,
	output logic fine_speed_step,
	output logic [6:0] station_active,
	output logic [2:0] baud_active,
	output logic link_err_led,
	output logic cmd_locked
);

	localparam int LW = $clog2(LOCK_CYCLES + 1);

	// Address decode shared by the strobes and the error answer.
	function automatic logic fbr_in_map(input logic [7:0] a);
		fbr_in_map = (a[1:0] == 2'b00) && (a <= FBR_OFF_MODE);
	endfunction

	////////////////////////////////////////////////////////////////////////
	// State.
	logic scope_q, sign_set_q;
	logic [3:0] start_q;
	logic [7:0] ext_q, res_q;
	logic [6:0] stn_pend_q, stn_act_q;
	logic [2:0] baud_pend_q, baud_act_q;
	fbr_mode_t mode_q;
	fbr_seq_t seq_q;
	logic [LW-1:0] lock_cnt_q;
	logic start_fwd_q, start_rev_q;
	logic [15:0] sp_word_q, freq_mag_q;
	logic freq_neg_q;
	logic [7:0] wr_err_q;
	logic err_rst_q, drv_rst_q, nvm_q, run_fwd_q, run_rev_q;
	logic [31:0] prdata_q;

	// Strobes and decoded requests.
	logic wr, wr_cfg, wr_link, wr_cmd, wr_sp, wr_instr, wr_mode;
	logic err_req, err_ok, drv_req, drv_ok, rst_take, clr_sp;
	logic vol, nv, do_wr, do_nvm, nv_refuse, ins_vol, ins_nv, ins_ok;
	logic [15:0] ins_data, dec_mag;
	logic dec_neg, dec_ok, pending, eff_neg;

	assign wr = psel && penable && pwrite && fbr_in_map(paddr);
	assign wr_cfg = wr && (paddr == FBR_OFF_CONFIG);
	assign wr_link = wr && (paddr == FBR_OFF_LINK);
	assign wr_cmd = wr && (paddr == FBR_OFF_CMD) && !cmd_locked;
	assign wr_sp = wr && (paddr == FBR_OFF_SETPOINT);
	assign wr_instr = wr && (paddr == FBR_OFF_INSTR) && !cmd_locked;
	assign wr_mode = wr && (paddr == FBR_OFF_MODE);
	assign cmd_locked = (seq_q != FBR_SEQ_IDLE);

	// Network reset acceptance.
	assign err_req = wr_cmd && pwdata[FBR_CMD_ERR_RST_BIT];
	assign err_ok = trip_active && !line_error
		&& (!scope_q || mode_q == FBR_MODE_NET);
	assign drv_req = wr_cmd && pwdata[FBR_CMD_DRV_RST_BIT];
	assign drv_ok = !line_error && (mode_q == FBR_MODE_NET);
	assign rst_take = (err_req && err_ok) || (drv_req && drv_ok);
	assign clr_sp = rst_take || hard_clear_terminal;

	// Setpoint write selection from the cyclic write bits.
	assign vol = wr_cmd && pwdata[FBR_CMD_VOL_BIT];
	assign nv = wr_cmd && pwdata[FBR_CMD_NV_BIT];
	assign do_wr = (vol || (nv && !sign_set_q)) && dec_ok;
	assign do_nvm = do_wr && nv && !sign_set_q && (!vol || ext_q != 8'h00);
	assign nv_refuse = nv && !vol && sign_set_q;

	// Instruction-code frequency writes carry a magnitude only.
	assign ins_data = pwdata[FBR_INSTR_DATA_LSB +: 16];
	assign ins_vol = wr_instr && (pwdata[7:0] == FBR_FREQ_WRITE_VOLATILE_CODE);
	assign ins_nv = wr_instr && (pwdata[7:0] == FBR_FREQ_WRITE_NONVOLATILE_CODE);
	assign ins_ok = sign_set_q ? !ins_data[15] : (ins_data <= FBR_UNSIGNED_MAX);
	assign pending = (stn_pend_q != stn_act_q) || (baud_pend_q != baud_act_q);
	assign eff_neg = sign_set_q && freq_neg_q;

	fbr_setpoint u_setpoint (
		.word(sp_word_q),
		.signed_mode(sign_set_q),
		.mag(dec_mag),
		.neg(dec_neg),
		.in_range(dec_ok)
	);

	fbr_blink #(.HALF_CYCLES(BLINK_CYCLES)) u_blink (
		.core_clk(core_clk),
		.sys_rst(sys_rst),
		.active(pending),
		.led(link_err_led)
	);

	////////////////////////////////////////////////////////////////////////
	// Configuration settings written by software.
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			scope_q <= 1'b0;
			sign_set_q <= 1'b0;
			start_q <= 4'h0;
			ext_q <= 8'h00;
			res_q <= 8'h00;
		end else if (wr_cfg) begin
			scope_q <= pwdata[FBR_CFG_SCOPE_BIT];
			sign_set_q <= pwdata[FBR_CFG_SIGN_BIT];
			start_q <= pwdata[FBR_CFG_START_LSB +: 4];
			ext_q <= pwdata[FBR_CFG_EXT_LSB +: 8];
			res_q <= pwdata[FBR_CFG_RES_LSB +: 8];
		end
	end

	// Pending link settings; out-of-range values are dropped.
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			stn_pend_q <= FBR_STN_RESET;
			baud_pend_q <= FBR_BAUD_RESET;
		end else if (wr_link) begin
			if (pwdata[FBR_LINK_STN_LSB +: 7] >= FBR_STN_MIN
				&& pwdata[FBR_LINK_STN_LSB +: 7] <= FBR_STN_MAX
				&& pwdata[7] == 1'b0) begin
				stn_pend_q <= pwdata[FBR_LINK_STN_LSB +: 7];
			end
			if (pwdata[FBR_LINK_BAUD_LSB +: 3] <= FBR_BAUD_MAX) begin
				baud_pend_q <= pwdata[FBR_LINK_BAUD_LSB +: 3];
			end
		end
	end

	// Active link settings follow only at power-on or the hard clear terminal.
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			stn_act_q <= FBR_STN_RESET;
			baud_act_q <= FBR_BAUD_RESET;
		end else if (hard_clear_terminal) begin
			stn_act_q <= stn_pend_q;
			baud_act_q <= baud_pend_q;
		end
	end

	// Operation mode: software selects it, a reset taken in network mode returns it.
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			mode_q <= FBR_MODE_EXT;
		end else if ((rst_take || hard_clear_terminal) && mode_q == FBR_MODE_NET) begin
			mode_q <= (start_q == 4'h0) ? FBR_MODE_EXT : FBR_MODE_NET;
		end else if (wr_mode && pwdata[1:0] != 2'b11) begin
			mode_q <= fbr_mode_t'(pwdata[1:0]);
		end
	end

	// Reset sequencer: one pulse, then a lockout of control commands.
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			seq_q <= FBR_SEQ_IDLE;
			lock_cnt_q <= '0;
		end else begin
			unique case (seq_q)
				FBR_SEQ_IDLE: begin
					lock_cnt_q <= '0;
					if (rst_take || hard_clear_terminal) begin
						seq_q <= FBR_SEQ_PULSE;
					end
				end
				FBR_SEQ_PULSE: begin
					if (!hard_clear_terminal) begin
						seq_q <= FBR_SEQ_LOCK;
					end
				end
				FBR_SEQ_LOCK: begin
					lock_cnt_q <= lock_cnt_q + LW'(1);
					if (hard_clear_terminal) begin
						seq_q <= FBR_SEQ_PULSE;
						lock_cnt_q <= '0;
					end else if (lock_cnt_q == LW'(LOCK_CYCLES - 1)) begin
						seq_q <= FBR_SEQ_IDLE;
					end
				end
				default: begin
					seq_q <= FBR_SEQ_IDLE;
				end
			endcase
		end
	end

	// Reset pulses to the drive core.
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			err_rst_q <= 1'b0;
			drv_rst_q <= 1'b0;
		end else begin
			err_rst_q <= err_req && err_ok;
			drv_rst_q <= drv_req && drv_ok;
		end
	end

	// Start command levels and setpoint word.
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			start_fwd_q <= 1'b0;
			start_rev_q <= 1'b0;
			sp_word_q <= 16'h0000;
		end else if (clr_sp) begin
			start_fwd_q <= 1'b0;
			start_rev_q <= 1'b0;
			sp_word_q <= 16'h0000;
		end else begin
			if (wr_cmd) begin
				start_fwd_q <= pwdata[FBR_CMD_FWD_BIT];
				start_rev_q <= pwdata[FBR_CMD_REV_BIT];
			end
			if (wr_sp) begin
				sp_word_q <= pwdata[15:0];
			end
		end
	end

	// Set frequency, sign and write-mode error.
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			freq_mag_q <= 16'h0000;
			freq_neg_q <= 1'b0;
			wr_err_q <= FBR_NO_ERROR_CODE;
			nvm_q <= 1'b0;
		end else if (clr_sp) begin
			freq_mag_q <= 16'h0000;
			freq_neg_q <= 1'b0;
			wr_err_q <= FBR_NO_ERROR_CODE;
			nvm_q <= 1'b0;
		end else begin
			nvm_q <= do_nvm || (ins_nv && ins_ok);
			if (do_wr) begin
				freq_mag_q <= dec_mag;
				freq_neg_q <= dec_neg;
				wr_err_q <= FBR_NO_ERROR_CODE;
			end else if (nv_refuse) begin
				wr_err_q <= FBR_WRITE_MODE_ERROR_CODE;
			end else if ((ins_vol || ins_nv) && ins_ok) begin
				freq_mag_q <= ins_data;
				wr_err_q <= FBR_NO_ERROR_CODE;
			end
		end
	end

	// Actual run direction combines the start command with the setpoint sign.
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			run_fwd_q <= 1'b0;
			run_rev_q <= 1'b0;
		end else begin
			run_fwd_q <= (start_fwd_q != start_rev_q) && (start_fwd_q != eff_neg);
			run_rev_q <= (start_fwd_q != start_rev_q) && (start_rev_q != eff_neg);
		end
	end

	// Read data is captured in the setup cycle and shown in the access cycle.
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			prdata_q <= 32'h0000_0000;
		end else if (psel && !penable) begin
			unique case (paddr)
				FBR_OFF_CONFIG: prdata_q <= {8'h00, res_q, ext_q, start_q, 2'b00, sign_set_q, scope_q};
				FBR_OFF_LINK: prdata_q <= {21'h00_0000, baud_pend_q, 1'b0, stn_pend_q};
				FBR_OFF_STATUS: prdata_q <= {5'h00, baud_act_q, 1'b0, stn_act_q, wr_err_q, 2'b00,
					line_error, trip_active, pending, cmd_locked, mode_q};
				FBR_OFF_CMD: prdata_q <= {26'h000_0000, start_rev_q, start_fwd_q, 4'h0};
				FBR_OFF_SETPOINT: prdata_q <= {16'h0000, sp_word_q};
				FBR_OFF_FREQ: prdata_q <= {15'h0000, freq_neg_q, freq_mag_q};
				FBR_OFF_MODE: prdata_q <= {30'h0000_0000, mode_q};
				default: prdata_q <= 32'h0000_0000;
			endcase
		end
	end

	// Outputs.
	assign prdata = prdata_q;
	assign pready = 1'b1;
	assign pslverr = psel && penable && !fbr_in_map(paddr);
	assign op_mode = mode_q;
	assign error_reset_pulse = err_rst_q;
	assign drive_reset_pulse = drv_rst_q;
	assign nvm_write_pulse = nvm_q;
	assign run_fwd = run_fwd_q;
	assign run_rev = run_rev_q;
	assign freq_mag = freq_mag_q;
	assign freq_neg = freq_neg_q;
	assign fine_speed_step = (res_q == FBR_RES_FINE_A) || (res_q == FBR_RES_FINE_B);
	assign station_active = stn_act_q;
	assign baud_active = baud_act_q;

	////////////////////////////////////////////////////////////////////////
	// Assertions.
	scope_any_mode_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		err_req && !scope_q && trip_active && !line_error |=> error_reset_pulse)
		else $error("error reset refused with scope zero");
	scope_net_only_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		err_req && scope_q && mode_q != FBR_MODE_NET |=> !error_reset_pulse)
		else $error("error reset taken outside network mode");
	trip_needed_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		error_reset_pulse |-> $past(trip_active))
		else $error("error reset without a trip");
	line_err_block_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		(err_req || drv_req) && line_error |=> !error_reset_pulse && !drive_reset_pulse)
		else $error("reset taken during line error");
	mode_return_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		rst_take && mode_q == FBR_MODE_NET && start_q == 4'h0 |=> op_mode == FBR_MODE_EXT)
		else $error("mode not external after reset");
	lockout_hold_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		rst_take |=> cmd_locked [*8])
		else $error("commands not locked after reset");
	station_range_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		stn_pend_q >= FBR_STN_MIN && stn_pend_q <= FBR_STN_MAX)
		else $error("station number out of range");
	led_dark_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		!pending && !$past(pending) |-> !link_err_led)
		else $error("indicator lit with settings applied");
	nv_refused_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		nv_refuse && !clr_sp |=> wr_err_q == FBR_WRITE_MODE_ERROR_CODE && $stable(freq_mag_q))
		else $error("signed nonvolatile write not refused");
	instr_sign_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		(ins_vol || ins_nv) && !do_wr && !clr_sp |=> $stable(freq_neg_q))
		else $error("instruction write changed sign");
	drv_net_only_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		drv_req && mode_q != FBR_MODE_NET |=> !drive_reset_pulse)
		else $error("drive reset outside network mode");

endmodule

// ===== verif/fbr_master_model.sv
// APB master model standing in for the fieldbus master station.
`timescale 1ns/1ps
module fbr_master_model import fbr_pkg::*; (
	// Clock and slave answer.
	input wire logic core_clk,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [31:0] prdata,
	// Request lines.
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [7:0] paddr,
	output logic [31:0] pwdata
);
	logic hang = 1'b0;
	logic [6:0] next_stn = 7'h01;
	logic [31:0] dq;
	logic de;
	// Bus idle at time zero.
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
	end
	// One transfer: setup, access until pready, then release with scrambled lines.
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic e);
		int n;
		@(posedge core_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge core_clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		hang = hang | (n >= 50);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		paddr <= ~a;
		pwdata <= ~d;
	endtask
	// Error reset asked for through its own command bit.
	task automatic err_reset();
		xfer(1'b1, FBR_OFF_CMD, 32'h0000_0001 << FBR_CMD_ERR_RST_BIT, dq, de);
	endtask
	// Station numbers handed out in sequence without gaps, wrapping from FBR_STN_MAX back to FBR_STN_MIN.
	task automatic next_link(input logic [2:0] b, output logic [6:0] stn);
		stn = next_stn;
		next_stn = (next_stn == FBR_STN_MAX) ? FBR_STN_MIN : next_stn + 7'h01;
		xfer(1'b1, FBR_OFF_LINK, {21'h00_0000, b, 1'b0, stn}, dq, de);
	endtask
endmodule

// ===== verif/fieldbus_reset_and_frequency_setup_bench.sv
// Self-checking bench for the fieldbus reset and frequency setup block.
`timescale 1ns/1ps
`define CHK(a, b) begin \
	check_count++; \
	if ((a) !== (b)) begin \
		error_cnt++; \
		$display("MISMATCH t=%0t got=%h exp=%h", $time, a, b); \
	end \
end
module fieldbus_reset_and_frequency_setup_bench import fbr_pkg::*; ();
	logic core_clk, sys_rst, psel, penable, pwrite, pready, pslverr;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata;
	logic trip_active, line_error, hard_clear_terminal, freq_neg, fine_speed_step;
	logic error_reset_pulse, drive_reset_pulse, nvm_write_pulse, run_fwd, run_rev;
	logic link_err_led, cmd_locked;
	logic [1:0] op_mode;
	logic [15:0] freq_mag;
	logic [6:0] station_active;
	logic [2:0] baud_active;
	int error_cnt = 0;
	int check_count = 0;
	int seed = 31;
	// Clock at 125 MHz.
	always #4 core_clk = ~core_clk;
	// Master model and design.
	fbr_master_model u_master (.core_clk(core_clk), .pready(pready), .pslverr(pslverr),
		.prdata(prdata), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata));
	fbr_top #(.LOCK_CYCLES(20), .BLINK_CYCLES(4)) u_dut (.core_clk(core_clk),
		.sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.trip_active(trip_active), .line_error(line_error),
		.hard_clear_terminal(hard_clear_terminal), .op_mode(op_mode),
		.error_reset_pulse(error_reset_pulse), .drive_reset_pulse(drive_reset_pulse),
		.nvm_write_pulse(nvm_write_pulse), .run_fwd(run_fwd), .run_rev(run_rev),
		.freq_mag(freq_mag), .freq_neg(freq_neg), .fine_speed_step(fine_speed_step),
		.station_active(station_active), .baud_active(baud_active),
		.link_err_led(link_err_led), .cmd_locked(cmd_locked));
	// Register write; returns just after the edge that takes it.
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		u_master.xfer(1'b1, a, d, u_master.dq, u_master.de);
		#1;
	endtask
	// Wait out the command lockout.
	task automatic wait_free();
		for (int n = 0; n < 100 && cmd_locked !== 1'b0; n++) @(negedge core_clk);
		`CHK(cmd_locked, 1'b0)
	endtask
	// Configuration word from its fields.
	function automatic logic [31:0] cfg(logic sc, logic sg, logic [3:0] st, logic [7:0] rs);
		return {8'h00, rs, 8'h01, st, 2'b00, sg, sc};
	endfunction
	// Counts, verdict and end of run.
	task automatic complete_run();
		$display("checks %0d mismatches %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	// Watchdog against a hang.
	initial begin
		#(100_000 * 8);
		error_cnt++;
		complete_run();
	end
	// Test sequence.
	initial begin
		logic [31:0] q;
		logic e, ex, en, dr, chg, prev;
		logic [15:0] w, em;
		logic [6:0] stn, sa;
		logic [2:0] b, ba;
		int r, tg;
		core_clk = 1'b0;
		sys_rst = 1'b1;
		trip_active = 1'b0;
		line_error = 1'b0;
		hard_clear_terminal = 1'b0;
		repeat (3) @(posedge core_clk);
		sys_rst <= 1'b0;
		@(negedge core_clk);
		`CHK({station_active, baud_active}, {FBR_STN_RESET, FBR_BAUD_RESET})
		`CHK({freq_neg, freq_mag}, 17'h0_0000)
		$display("reset values done");
		// Error reset over scope, mode, trip and line error.
		for (int i = 0; i < 24; i++) begin
			wr(FBR_OFF_CONFIG, cfg(i[4], 1'b0, i[4] ? 4'h2 : 4'h0, 8'h00));
			wr(FBR_OFF_MODE, 32'(i[3:2] % 3));
			@(posedge core_clk);
			trip_active <= i[0];
			line_error <= i[1];
			u_master.err_reset();
			#1;
			ex = i[0] && !i[1] && (!i[4] || i[3:2] % 3 == 1);
			`CHK(error_reset_pulse, ex)
			@(negedge core_clk);
			`CHK(cmd_locked, ex)
			wait_free();
			`CHK(op_mode, (ex && i[3:2] % 3 == 1) ? {1'b0, i[4]} : 2'(i[3:2] % 3))
		end
		$display("error reset done");
		// Drive reset per mode, under lockout and with line error.
		for (int m = 0; m < 4; m++) begin
			@(posedge core_clk);
			trip_active <= 1'b0;
			line_error <= (m == 3);
			wr(FBR_OFF_MODE, (m == 3) ? 32'h0000_0001 : 32'(m));
			wr(FBR_OFF_CMD, 32'h0000_0008);
			`CHK(drive_reset_pulse, m == 1)
			wr(FBR_OFF_CMD, 32'h0000_0008);
			`CHK(drive_reset_pulse, 1'b0)
			wait_free();
		end
		@(posedge core_clk);
		line_error <= 1'b0;
		$display("drive reset done");
		// Setpoint decoding and run direction, corners then random.
		en = 1'b0;
		em = 16'h0000;
		for (int i = 0; i < 16; i++) begin
			r = $random(seed);
			w = r[15:0];
			dr = r[16];
			case (i)
				0: w = 16'hE678;
				1: w = 16'hE679;
				2: w = 16'h8000;
				3: w = 16'hFFFF;
				default: if (!i[1]) w = w % 16'hE679;
			endcase
			wr(FBR_OFF_CONFIG, cfg(1'b0, i[1], 4'h0, 8'h00));
			wr(FBR_OFF_SETPOINT, {16'h0000, w});
			wr(FBR_OFF_CMD, dr ? 32'h0000_0022 : 32'h0000_0012);
			if (i[1] || w <= FBR_UNSIGNED_MAX) begin
				en = i[1] & w[15];
				em = en ? ~w + 16'h0001 : w;
			end
			@(negedge core_clk);
			`CHK({freq_neg, freq_mag}, {en, em})
			// Run direction is registered one cycle after the start bits and the sign.
			@(negedge core_clk);
			`CHK({run_rev, run_fwd}, {dr ^ en, ~(dr ^ en)})
		end
		// Nonvolatile store: unsigned with extended setting zero, then nonzero, then signed.
		wr(FBR_OFF_SETPOINT, 32'h0000_7530);
		for (int s = 0; s < 3; s++) begin
			wr(FBR_OFF_CONFIG, cfg(1'b0, s[1], 4'h0, 8'h00) & ~{23'h00_0000, s == 0, 8'h00});
			wr(FBR_OFF_CMD, 32'h0000_0016);
			`CHK(nvm_write_pulse, s == 1)
			wr(FBR_OFF_CMD, 32'h0000_0014);
			`CHK(nvm_write_pulse, !s[1])
			u_master.xfer(1'b0, FBR_OFF_STATUS, 32'h0000_0000, q, e);
			`CHK(q[15:8], s[1] ? FBR_WRITE_MODE_ERROR_CODE : FBR_NO_ERROR_CODE)
			`CHK(freq_mag, 16'h7530)
		end
		// Instruction writes keep a negative sign.
		wr(FBR_OFF_SETPOINT, 32'h0000_FC18);
		wr(FBR_OFF_CMD, 32'h0000_0012);
		for (int c = 0; c < 2; c++) begin
			wr(FBR_OFF_INSTR, {16'h1234 + 16'(c), 8'h00,
				c ? FBR_FREQ_WRITE_NONVOLATILE_CODE : FBR_FREQ_WRITE_VOLATILE_CODE});
			@(negedge core_clk);
			`CHK({freq_neg, freq_mag}, {1'b1, 16'h1234 + 16'(c)})
		end
		// Resolution switch values.
		for (int j = 0; j < 4; j++) begin
			wr(FBR_OFF_CONFIG, cfg(1'b0, 1'b0, 4'h0, (j < 2) ? 8'(1 + j * 10) : 8'(j * 5)));
			`CHK(fine_speed_step, j < 2)
		end
		$display("setpoint done");
		// Link settings: refused values, pending flash, apply on hard clear.
		wr(FBR_OFF_LINK, 32'h0000_0500);
		wr(FBR_OFF_LINK, 32'h0000_0041);
		u_master.xfer(1'b0, FBR_OFF_LINK, 32'h0000_0000, q, e);
		`CHK({q[10:8], q[6:0]}, 10'h001)
		u_master.xfer(1'b0, 8'h20, 32'h0000_0000, q, e);
		`CHK({e, q}, {1'b1, 32'h0000_0000})
		sa = FBR_STN_RESET;
		ba = FBR_BAUD_RESET;
		u_master.next_stn = 7'h3F;
		for (int i = 0; i < 4; i++) begin
			r = $random(seed);
			b = 3'(r[7:0] % 5);
			u_master.next_link(b, stn);
			chg = (stn != sa) || (b != ba);
			tg = 0;
			prev = link_err_led;
			repeat (12) begin
				@(negedge core_clk);
				tg += (link_err_led !== prev);
				prev = link_err_led;
			end
			`CHK({tg != 0, station_active}, {chg, sa})
			@(posedge core_clk);
			hard_clear_terminal <= 1'b1;
			@(posedge core_clk);
			hard_clear_terminal <= 1'b0;
			repeat (2) @(negedge core_clk);
			sa = stn;
			ba = b;
			`CHK({station_active, baud_active, link_err_led}, {sa, ba, 1'b0})
			`CHK({freq_neg, freq_mag}, 17'h0_0000)
			wait_free();
		end
		$display("link settings done");
		`CHK(u_master.hang, 1'b0)
		complete_run();
	end
endmodule
